//--- core/hsbfl_core.sv
`timescale 1ns/1ps
// What this block does
// (R1) arm detectors after power-on delay and enable rise
// (R2) power good needs output high and gate enhanced
// (R3) primary strong source on while untriggered
// (R4) on trigger drop source, then enable weak sink
// (R5) cap low starts default timer; expiry trips
// (R6) floating cap gives only the default delay
// (R7) trip: gate off, fault pulldown, discharge high
// (R8) latched breaker sets current fault; good drops
// (R9) select secondary level from two select inputs
// (R10) secondary hit trips within response time
// (R11) enable falling resets a tripped breaker
// (R12) reset completes after delay; fault clears
// (R13) other side holds enable low minimum width
// (R14) retry strong sink on before any trip
// (R15) trip swaps retry sink for weak source
// (R16) retry cap high resets breaker, restores sink
// (R17) retry cap low re-enables gate, discharge low
// (R18) persistent overcurrent keeps retry cycling
// (R19) secondary trips retry the same way
// (R20) enable low: weak gate sink, gate monitored
// (R21) gate short sets hardware fault immediately
// (R22) hardware fault held until regulator lockout low
// (R23) current fault clears within five microseconds
// (R24) enable low minimum is two hundred microseconds
// (R25) comparator inputs synchronised before use
// (R26) delays are parameterised cycle counters
module hsbfl_core #(
  parameter int unsigned POR_CYCLES     = hsbfl_pkg::POR_CYC,
  parameter int unsigned PRI_DEF_CYCLES = hsbfl_pkg::PRI_DEF_CYC,
  parameter int unsigned EN_LOW_CYCLES  = hsbfl_pkg::EN_LOW_CYC
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       enable_in,
  input  wire logic [1:0] sec_level_sel,
  input  wire logic       primary_over,
  input  wire logic [3:0] sec_level_hit,
  input  wire logic       primary_cap_low,
  input  wire logic       retry_cap_high,
  input  wire logic       retry_cap_low,
  input  wire logic       output_above_high,
  input  wire logic       output_above_low,
  input  wire logic       gate_enhanced,
  input  wire logic       gate_above_short,
  input  wire logic       reg_above_lockout_high,
  input  wire logic       reg_above_lockout_low,
  output logic            detectors_armed,
  output logic            gate_drive_en,
  output logic            gate_weak_sink,
  output logic            gate_fault_pulldown,
  output logic            discharge_drive,
  output logic            primary_strong_source,
  output logic            primary_weak_sink,
  output logic            retry_strong_sink,
  output logic            retry_weak_source,
  output logic            current_fault_flag,
  output logic            power_good_out,
  output logic            hardware_fault_flag
);

  localparam int TW = hsbfl_pkg::TMR_W;

  hsbfl_pkg::hsbfl_core_type r;
  hsbfl_pkg::hsbfl_core_type next_r;

  logic [hsbfl_pkg::IN_W-1:0] raw_in;
  logic                       en;
  logic                       en_rise;
  logic                       pri_over;
  logic                       sec_hit;
  logic                       pcap_low;
  logic                       rcap_high;
  logic                       rcap_low;
  logic                       out_high;
  logic                       out_low;
  logic                       gate_enh;
  logic                       gate_short;
  logic                       reg_high;
  logic                       reg_ok;
  logic                       low_ok;

  // selects the comparator of the chosen secondary trip level
  function automatic logic sec_select(input logic [3:0] hits,
                                      input logic [1:0] sel);
    sec_select = hits[sel];
  endfunction

  // all comparators and pins are asynchronous to clock
  assign raw_in = {reg_above_lockout_low, reg_above_lockout_high,
                   gate_above_short, gate_enhanced, output_above_low,
                   output_above_high, retry_cap_low, retry_cap_high,
                   primary_cap_low, sec_level_hit, primary_over,
                   sec_level_sel, enable_in};

  assign en         = r.sync2[hsbfl_pkg::IN_EN];
  assign pri_over   = r.sync2[hsbfl_pkg::IN_PRI_OVER];
  assign pcap_low   = r.sync2[hsbfl_pkg::IN_PCAP_LOW];
  assign rcap_high  = r.sync2[hsbfl_pkg::IN_RCAP_HIGH];
  assign rcap_low   = r.sync2[hsbfl_pkg::IN_RCAP_LOW];
  assign out_high   = r.sync2[hsbfl_pkg::IN_OUT_HIGH];
  assign out_low    = r.sync2[hsbfl_pkg::IN_OUT_LOW];
  assign gate_enh   = r.sync2[hsbfl_pkg::IN_GATE_ENH];
  assign gate_short = r.sync2[hsbfl_pkg::IN_GATE_SHT];
  assign reg_high   = r.sync2[hsbfl_pkg::IN_REG_HIGH];
  assign reg_ok     = r.sync2[hsbfl_pkg::IN_REG_LOW];
  assign en_rise    = en & ~r.en_prev;
  assign low_ok     = r.low_cnt >= TW'(EN_LOW_CYCLES);
  assign sec_hit    = sec_select(                                   // R9
    r.sync2[hsbfl_pkg::IN_SEC_LO +: 4],
    r.sync2[hsbfl_pkg::IN_SEL_LO +: 2]);

  always_comb begin
    next_r       = r;
    next_r.sync1 = raw_in;                                          // R25
    next_r.sync2 = r.sync1;                                         // R25
    next_r.en_prev = en;

    // a rising enable after too short a low time is not a new start
    if (en) begin
      next_r.low_cnt = {TW{1'h0}};
    end else if (!low_ok) begin
      next_r.low_cnt = r.low_cnt + TW'(1);                          // R26
    end

    // hysteresis: set on the upper level, lost on the lower one
    if (out_high && gate_enh) begin
      next_r.pgood = 1'h1;                                          // R2
    end else if (!out_low || !gate_enh) begin
      next_r.pgood = 1'h0;                                          // R8
    end

    case (r.state)
      hsbfl_pkg::ST_POR: begin
        next_r.pgood   = 1'h0;
        next_r.en_prev = 1'h0;
        if (!reg_high) begin
          next_r.tmr = {TW{1'h0}};
        end else if (r.tmr == TW'(POR_CYCLES - 1)) begin            // R26
          next_r.state   = hsbfl_pkg::ST_OFF;
          next_r.tmr     = {TW{1'h0}};
          next_r.low_cnt = TW'(EN_LOW_CYCLES);
        end else begin
          next_r.tmr = r.tmr + TW'(1);
        end
      end
      hsbfl_pkg::ST_OFF: begin
        next_r.armed = 1'h0;
        if (gate_short) begin
          next_r.hw_fault = 1'h1;                                   // R21
        end
        if (en_rise && low_ok && !r.hw_fault) begin
          next_r.state = hsbfl_pkg::ST_ON;                          // R1
          next_r.armed = 1'h1;
        end
      end
      hsbfl_pkg::ST_ON: begin
        if (!en) begin
          next_r.state = hsbfl_pkg::ST_OFF;
        end else if (sec_hit) begin
          next_r.state = hsbfl_pkg::ST_TRIP;                        // R10
        end else if (pri_over) begin
          next_r.state = hsbfl_pkg::ST_PRI_GAP;                     // R4
        end
      end
      hsbfl_pkg::ST_PRI_GAP: begin
        // one cycle with both primary drivers off avoids overlap
        if (!en) begin
          next_r.state = hsbfl_pkg::ST_OFF;
        end else if (sec_hit) begin
          next_r.state = hsbfl_pkg::ST_TRIP;
        end else begin
          next_r.state = hsbfl_pkg::ST_PRI_SINK;                    // R4
        end
      end
      hsbfl_pkg::ST_PRI_SINK: begin
        next_r.tmr = {TW{1'h0}};
        if (!en) begin
          next_r.state = hsbfl_pkg::ST_OFF;
        end else if (sec_hit) begin
          next_r.state = hsbfl_pkg::ST_TRIP;
        end else if (pcap_low) begin
          next_r.state = hsbfl_pkg::ST_PRI_TIMER;                   // R5 R6
        end else if (!pri_over) begin
          next_r.state = hsbfl_pkg::ST_ON;
        end
      end
      hsbfl_pkg::ST_PRI_TIMER: begin
        if (!en) begin
          next_r.state = hsbfl_pkg::ST_OFF;
        end else if (sec_hit) begin
          next_r.state = hsbfl_pkg::ST_TRIP;
        end else if (r.tmr == TW'(PRI_DEF_CYCLES - 1)) begin        // R5
          next_r.state = hsbfl_pkg::ST_TRIP;
        end else begin
          next_r.tmr = r.tmr + TW'(1);                              // R26
        end
      end
      hsbfl_pkg::ST_TRIP: begin
        next_r.tmr = {TW{1'h0}};
        if (!en) begin
          next_r.state = hsbfl_pkg::ST_CB_RESET;                    // R11
        end else if (rcap_high) begin
          next_r.state   = hsbfl_pkg::ST_RETRY_DRAIN;               // R16 R19
          next_r.breaker = 1'h0;
          next_r.fault   = 1'h0;
        end
      end
      hsbfl_pkg::ST_CB_RESET: begin
        if (r.tmr == TW'(hsbfl_pkg::CB_RST_COUNT - 1)) begin        // R12
          next_r.state   = hsbfl_pkg::ST_OFF;
          next_r.breaker = 1'h0;
          next_r.fault   = 1'h0;                                    // R23
          next_r.tmr     = {TW{1'h0}};
        end else begin
          next_r.tmr = r.tmr + TW'(1);
        end
      end
      hsbfl_pkg::ST_RETRY_DRAIN: begin
        if (!en) begin
          next_r.state = hsbfl_pkg::ST_OFF;
        end else if (rcap_low) begin
          next_r.state = hsbfl_pkg::ST_ON;                          // R17 R18
          next_r.armed = 1'h1;
        end
      end
      default: begin
        next_r.state = hsbfl_pkg::ST_POR;
      end
    endcase

    // every path into the trip state latches the breaker
    if (next_r.state == hsbfl_pkg::ST_TRIP
        && r.state != hsbfl_pkg::ST_TRIP) begin
      next_r.breaker = 1'h1;                                        // R7
      next_r.fault   = 1'h1;                                        // R8
      next_r.armed   = 1'h0;
    end

    // regulator lockout clears all but the synchroniser, the hardware fault too
    if (!reg_ok) begin
      next_r       = hsbfl_pkg::CORE_RESET;                         // R22
      next_r.sync1 = raw_in;
      next_r.sync2 = r.sync1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= hsbfl_pkg::CORE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign detectors_armed     = r.armed;
  assign gate_drive_en       = r.state == hsbfl_pkg::ST_ON
                            || r.state == hsbfl_pkg::ST_PRI_GAP
                            || r.state == hsbfl_pkg::ST_PRI_SINK
                            || r.state == hsbfl_pkg::ST_PRI_TIMER;
  assign gate_weak_sink      = r.state == hsbfl_pkg::ST_OFF;          // R20
  assign gate_fault_pulldown = r.breaker
                            || r.state == hsbfl_pkg::ST_RETRY_DRAIN
                            || r.state == hsbfl_pkg::ST_POR;          // R7
  assign discharge_drive     = r.breaker
                            || r.state == hsbfl_pkg::ST_RETRY_DRAIN;  // R7 R17
  assign primary_weak_sink   = r.state == hsbfl_pkg::ST_PRI_SINK
                            || r.state == hsbfl_pkg::ST_PRI_TIMER;    // R4
  assign primary_strong_source = !primary_weak_sink
                            && r.state != hsbfl_pkg::ST_PRI_GAP;      // R3 R5
  assign retry_weak_source   = r.state == hsbfl_pkg::ST_TRIP;         // R15
  assign retry_strong_sink   = !retry_weak_source;                   // R14 R16
  assign current_fault_flag  = r.fault;
  assign power_good_out      = r.pgood;
  assign hardware_fault_flag = r.hw_fault;

  AST_ARM_AFTER_POR: assert property ( // R1
    @(posedge clock) disable iff (!nrst)
    $rose(r.armed) |-> $past(r.state) != hsbfl_pkg::ST_POR
                       && (en || $past(en)))
    else $error("detectors armed without power-on delay or enable");

  AST_PGOOD_CAUSE: assert property ( // R2
    @(posedge clock) disable iff (!nrst)
    $rose(power_good_out) |-> $past(out_high) && $past(gate_enh))
    else $error("power good rose without output and gate levels");

  AST_PRI_SOURCE_IDLE: assert property ( // R3
    @(posedge clock) disable iff (!nrst)
    r.state == hsbfl_pkg::ST_ON |-> primary_strong_source
                                    && !primary_weak_sink)
    else $error("primary source not held while untriggered");

  AST_PRI_BREAK_BEFORE: assert property ( // R4
    @(posedge clock) disable iff (!nrst)
    $fell(primary_strong_source) |-> !primary_weak_sink)
    else $error("primary sink enabled together with source drop");

  AST_PRI_TIMER_TRIP: assert property ( // R5
    @(posedge clock) disable iff (!nrst)
    r.state == hsbfl_pkg::ST_PRI_TIMER && en && reg_ok && !sec_hit
    && r.tmr == TW'(PRI_DEF_CYCLES - 1)
    |=> r.breaker && primary_strong_source && !primary_weak_sink)
    else $error("default timer expiry did not trip breaker");

  AST_TRIP_OUTPUTS: assert property ( // R7
    @(posedge clock) disable iff (!nrst)
    r.breaker |-> !gate_drive_en && gate_fault_pulldown
                  && discharge_drive && current_fault_flag)
    else $error("tripped breaker without gate off and discharge");

  AST_SEC_TRIP: assert property ( // R10
    @(posedge clock) disable iff (!nrst)
    r.state == hsbfl_pkg::ST_ON && en && sec_hit && reg_ok
    |=> r.breaker)
    else $error("secondary hit did not trip next cycle");

  AST_CB_RESET_TIME: assert property ( // R23
    @(posedge clock) disable iff (!nrst)
    r.state == hsbfl_pkg::ST_TRIP && !en && reg_ok
    |-> ##[1:998] !current_fault_flag)
    else $error("current fault not cleared after enable low");

  AST_RETRY_SWAP: assert property ( // R15
    @(posedge clock) disable iff (!nrst)
    $rose(r.breaker) |-> retry_weak_source && !retry_strong_sink)
    else $error("retry pin not charging after trip");

  AST_RETRY_RESET: assert property ( // R16
    @(posedge clock) disable iff (!nrst)
    r.state == hsbfl_pkg::ST_TRIP && en && rcap_high && reg_ok
    |=> !r.breaker && !current_fault_flag && retry_strong_sink
        && !gate_drive_en)
    else $error("retry level did not reset breaker");

  AST_GATE_SHORT: assert property ( // R21
    @(posedge clock) disable iff (!nrst)
    r.state == hsbfl_pkg::ST_OFF && gate_short && reg_ok
    |=> hardware_fault_flag)
    else $error("gate short did not latch hardware fault");

  AST_HW_HOLD: assert property ( // R22
    @(posedge clock) disable iff (!nrst)
    hardware_fault_flag && reg_ok |=> hardware_fault_flag)
    else $error("hardware fault lost without lockout");

endmodule

//--- inc/hsbfl_pkg.sv
package hsbfl_pkg;

  // clock
  localparam int CLK_PERIOD_NS     = 5;

  // delays in their own units, figures as printed
  localparam int POR_DELAY_NS      = 6500000;
  localparam int PRI_DEFAULT_US    = 250;
  localparam int SEC_RESPONSE_NS   = 500;
  localparam int CB_RESET_US       = 5;
  localparam int ENABLE_LOW_MIN_US = 200;

  // derived cycle counts: longest times round down, least times round up
  localparam int POR_CYC      = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int PRI_DEF_CYC  = (PRI_DEFAULT_US * 1000) / CLK_PERIOD_NS;
  localparam int SEC_RESP_CYC = SEC_RESPONSE_NS / CLK_PERIOD_NS;
  localparam int CB_RST_CYC   = (CB_RESET_US * 1000) / CLK_PERIOD_NS;
  localparam int EN_LOW_CYC   = (ENABLE_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

  // input synchroniser depth; breaker reset count leaves room for it
  localparam int SYNC_STAGES  = 2;
  localparam int CB_RST_COUNT = CB_RST_CYC - SYNC_STAGES - 1;

  localparam int TMR_W = 24;

  // bit positions of the synchronised input vector
  localparam int IN_EN        = 0;
  localparam int IN_SEL_LO    = 1;
  localparam int IN_PRI_OVER  = 3;
  localparam int IN_SEC_LO    = 4;
  localparam int IN_PCAP_LOW  = 8;
  localparam int IN_RCAP_HIGH = 9;
  localparam int IN_RCAP_LOW  = 10;
  localparam int IN_OUT_HIGH  = 11;
  localparam int IN_OUT_LOW   = 12;
  localparam int IN_GATE_ENH  = 13;
  localparam int IN_GATE_SHT  = 14;
  localparam int IN_REG_HIGH  = 15;
  localparam int IN_REG_LOW   = 16;
  localparam int IN_W         = 17;

  typedef enum logic [3:0] {
    ST_POR, ST_OFF, ST_ON, ST_PRI_GAP, ST_PRI_SINK, ST_PRI_TIMER,
    ST_TRIP, ST_CB_RESET, ST_RETRY_DRAIN
  } hsbfl_state_type;

  typedef struct packed {
    logic [IN_W-1:0]  sync1;
    logic [IN_W-1:0]  sync2;
    hsbfl_state_type  state;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] low_cnt;
    logic             en_prev;
    logic             armed;
    logic             breaker;
    logic             fault;
    logic             pgood;
    logic             hw_fault;
  } hsbfl_core_type;

  localparam hsbfl_core_type CORE_RESET = '{
    sync1:    {IN_W{1'h0}},
    sync2:    {IN_W{1'h0}},
    state:    ST_POR,
    tmr:      {TMR_W{1'h0}},
    low_cnt:  {TMR_W{1'h0}},
    en_prev:  1'h0,
    armed:    1'h0,
    breaker:  1'h0,
    fault:    1'h0,
    pgood:    1'h0,
    hw_fault: 1'h0
  };

endpackage

//--- test/hot_swap_breaker_fault_logic_bench.sv
`timescale 1ns/1ps
module hot_swap_breaker_fault_logic_bench;
  localparam int POR   = 20;
  localparam int PDEF  = 10;
  localparam int ENLOW = 8;
  localparam int RCHG  = 30;
  typedef struct packed {
    logic [1:0] sel;
    logic [3:0] hit;
    logic       trip;
  } hsbfl_row_type;
  logic          clock, nrst, enable_in, primary_over, gate_above_short;
  logic [1:0]    sec_level_sel;
  logic [3:0]    sec_level_hit;
  logic          reg_hi, reg_lo, pcap_fit, retry_fit;
  logic          gate_enhanced, output_above_high, output_above_low;
  logic          primary_cap_low, retry_cap_high, retry_cap_low;
  logic          detectors_armed, gate_drive_en, gate_weak_sink;
  logic          gate_fault_pulldown, discharge_drive;
  logic          primary_strong_source, primary_weak_sink;
  logic          retry_strong_sink, retry_weak_source;
  logic          current_fault_flag, power_good_out, hardware_fault_flag;
  int            bad_count, checks_done, n, i;
  hsbfl_row_type rows [8];

  hsbfl_core #(
    .POR_CYCLES(POR), .PRI_DEF_CYCLES(PDEF), .EN_LOW_CYCLES(ENLOW)
  ) u_hsbfl_core (
    .clock(clock), .nrst(nrst), .enable_in(enable_in),
    .sec_level_sel(sec_level_sel), .primary_over(primary_over),
    .sec_level_hit(sec_level_hit), .primary_cap_low(primary_cap_low),
    .retry_cap_high(retry_cap_high), .retry_cap_low(retry_cap_low),
    .output_above_high(output_above_high),
    .output_above_low(output_above_low), .gate_enhanced(gate_enhanced),
    .gate_above_short(gate_above_short),
    .reg_above_lockout_high(reg_hi), .reg_above_lockout_low(reg_lo),
    .detectors_armed(detectors_armed), .gate_drive_en(gate_drive_en),
    .gate_weak_sink(gate_weak_sink),
    .gate_fault_pulldown(gate_fault_pulldown),
    .discharge_drive(discharge_drive),
    .primary_strong_source(primary_strong_source),
    .primary_weak_sink(primary_weak_sink),
    .retry_strong_sink(retry_strong_sink),
    .retry_weak_source(retry_weak_source),
    .current_fault_flag(current_fault_flag),
    .power_good_out(power_good_out),
    .hardware_fault_flag(hardware_fault_flag));

  hsbfl_far_side #(.RCHG(RCHG)) u_hsbfl_far_side (
    .clock(clock), .nrst(nrst), .pcap_fit(pcap_fit),
    .retry_fit(retry_fit), .gate_drive_en(gate_drive_en),
    .primary_weak_sink(primary_weak_sink),
    .retry_weak_source(retry_weak_source),
    .retry_strong_sink(retry_strong_sink), .gate_enhanced(gate_enhanced),
    .output_above_high(output_above_high),
    .output_above_low(output_above_low),
    .primary_cap_low(primary_cap_low), .retry_cap_high(retry_cap_high),
    .retry_cap_low(retry_cap_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, want);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = current_fault_flag;
      1: pick = gate_weak_sink;
      2: pick = power_good_out;
      3: pick = discharge_drive;
      default: pick = gate_drive_en;
    endcase
  endfunction
  // bounded wait on falling edges; n holds the cycles spent
  task automatic wait_for(input int k, input logic v, input int lim);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic steps(input int c);
    repeat (c) @(negedge clock);
  endtask
  task automatic arm;
    enable_in = 1'h1;
    steps(3);
    check(detectors_armed, 1'h1);
    check(gate_drive_en, 1'h1);
    wait_for(2, 1'h1, 20);
    check(power_good_out, 1'h1);
  endtask
  task automatic release_en(input logic tripped);
    enable_in = 1'h0;
    if (tripped) begin
      wait_for(0, 1'h0, 1100);
      check(n <= 1000, 1'h1);
    end
    steps(ENLOW + 4);
  endtask
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    test_done();
  end
  initial begin
    nrst = 1'h0;
    enable_in = 1'h0;
    primary_over = 1'h0;
    gate_above_short = 1'h0;
    sec_level_sel = 2'h0;
    sec_level_hit = 4'h0;
    reg_hi = 1'h1;
    reg_lo = 1'h1;
    pcap_fit = 1'h0;
    retry_fit = 1'h0;
    bad_count = 0;
    checks_done = 0;
    for (i = 0; i < 4; i++) begin
      rows[i] = '{i[1:0], 4'h1 << i, 1'h1};
      rows[i + 4] = '{i[1:0], ~(4'h1 << i), 1'h0};
    end
    steps(8);
    check(primary_strong_source, 1'h1);
    check(retry_strong_sink, 1'h1);
    check({detectors_armed, current_fault_flag, discharge_drive}, 3'h0);
    nrst = 1'h1;
    wait_for(1, 1'h1, 60);
    check(n >= POR, 1'h1);
    check(gate_weak_sink, 1'h1);
    check(detectors_armed, 1'h0);
    steps(ENLOW + 4);
    end_test("reset");
    for (i = 0; i < 8; i++) begin
      sec_level_sel = rows[i].sel;
      arm();
      sec_level_hit = rows[i].hit;
      steps(3);
      check(current_fault_flag, rows[i].trip);
      check(discharge_drive, rows[i].trip);
      check(gate_fault_pulldown, rows[i].trip);
      check(gate_drive_en, !rows[i].trip);
      check(retry_weak_source, rows[i].trip);
      check(retry_strong_sink, !rows[i].trip);
      sec_level_hit = 4'h0;
      if (rows[i].trip) begin
        wait_for(2, 1'h0, 20);
        check(power_good_out, 1'h0);
      end
      release_en(rows[i].trip);
    end
    end_test("table");
    arm();
    primary_over = 1'h1;
    steps(3);
    check({primary_strong_source, primary_weak_sink}, 2'h0);
    steps(1);
    check(primary_weak_sink, 1'h1);
    wait_for(3, 1'h1, PDEF + 20);
    check(n >= PDEF && n <= PDEF + 10, 1'h1);
    check({primary_strong_source, primary_weak_sink}, 2'h2);
    primary_over = 1'h0;
    release_en(1'h1);
    end_test("primary");
    pcap_fit = 1'h1;
    retry_fit = 1'h1;
    arm();
    primary_over = 1'h1;
    wait_for(3, 1'h1, PDEF + 40);
    check(retry_weak_source, 1'h1);
    wait_for(0, 1'h0, RCHG + 20);
    check({retry_strong_sink, retry_weak_source}, 2'h2);
    check(discharge_drive, 1'h1);
    wait_for(4, 1'h1, RCHG + 20);
    check({gate_drive_en, discharge_drive}, 2'h2);
    wait_for(3, 1'h1, PDEF + 40);
    check(current_fault_flag, 1'h1);
    primary_over = 1'h0;
    wait_for(4, 1'h1, 3 * RCHG);
    check(gate_drive_en, 1'h1);
    end_test("retry");
    sec_level_sel = 2'h2;
    steps(3);
    sec_level_hit = 4'h4;
    steps(3);
    check(current_fault_flag, 1'h1);
    sec_level_hit = 4'h0;
    wait_for(4, 1'h1, 3 * RCHG);
    check({gate_drive_en, current_fault_flag}, 2'h2);
    release_en(1'h0);
    end_test("second");
    gate_above_short = 1'h1;
    steps(3);
    check(hardware_fault_flag, 1'h1);
    gate_above_short = 1'h0;
    enable_in = 1'h1;
    steps(5);
    check({hardware_fault_flag, detectors_armed}, 2'h2);
    reg_lo = 1'h0;
    steps(4);
    check({hardware_fault_flag, gate_fault_pulldown}, 2'h1);
    end_test("hwfault");
    test_done();
  end
endmodule

//--- test/hsbfl_far_side.sv
`timescale 1ns/1ps
module hsbfl_far_side #(
  parameter int RAMP = 4,
  parameter int PDIS = 6,
  parameter int RCHG = 30
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pcap_fit,
  input  wire logic retry_fit,
  input  wire logic gate_drive_en,
  input  wire logic primary_weak_sink,
  input  wire logic retry_weak_source,
  input  wire logic retry_strong_sink,
  output logic      gate_enhanced,
  output logic      output_above_high,
  output logic      output_above_low,
  output logic      primary_cap_low,
  output logic      retry_cap_high,
  output logic      retry_cap_low
);
  int gate_lvl;
  int pcap_lvl;
  int rcap_lvl;
  // one step a cycle, so gate and retry thresholds are crossed late, never at once
  always @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_lvl <= 0;
      pcap_lvl <= 0;
      rcap_lvl <= 0;
    end else begin
      if (gate_drive_en && gate_lvl < RAMP) gate_lvl <= gate_lvl + 1;
      else if (!gate_drive_en && gate_lvl > 0) gate_lvl <= gate_lvl - 1;
      // strong source refills the cap at once
      pcap_lvl <= primary_weak_sink ? pcap_lvl + 1 : 0;
      if (retry_weak_source && rcap_lvl < RCHG) rcap_lvl <= rcap_lvl + 1;
      else if (retry_strong_sink && rcap_lvl > 0) rcap_lvl <= rcap_lvl - 1;
    end
  end
  assign gate_enhanced     = gate_lvl == RAMP;
  assign output_above_high = gate_lvl >= RAMP - 1;
  assign output_above_low  = gate_lvl > 0;
  // open pin: weak sink pulls it below the low level at once
  assign primary_cap_low   = pcap_fit ? pcap_lvl >= PDIS : primary_weak_sink;
  // no retry cap fitted: pin grounded, breaker stays latched
  assign retry_cap_high    = retry_fit && rcap_lvl >= RCHG;
  assign retry_cap_low     = !retry_fit || rcap_lvl == 0;
endmodule
